// >>> src/wts_defines.svh
// Register map, field ranges and reset values for the tension setpoint block.
// Behaviour
// - Eight data sets 0..7 each hold initial diameter, thickness and final diameter.
// - Host's three selection inputs choose the active data set.
// - Initial diameter below final diameter means winding.
// - Initial diameter above final diameter means unwinding.
// - Thickness accepts 1..5000 um, default 50.
// - Initial diameter accepts 1..1000 mm, default 500.
// - Final diameter accepts 1..1000 mm, default 1000.
// - Each set holds core and material inertia, 0..9999999 hundredths, default 0.
// - Maximum diameter is final when winding, initial when unwinding.
// - Each set holds taper 0..100 percent, default 100.
// - Tension falls linearly from command at zero to command times taper at maximum.
// - Taper 100 keeps tension equal to the command.
// - Forward run input starts operation at the selected command.
// - Reverse run input is ignored.
// - Active set does not change while forward run is on.
// - Releasing forward run removes excitation for a coast stop.
// - Friction correction 0..50 percent, default 0, offsets the torque.
// - Gear ratio 1.0..1000.0, default 1.0, scales the computation.
// - Gear ratio and direction take effect only at the next reload.
// - Filter time constant 10..500 ms, default 100.
// - Tension direction follows the direction setting, not the run input.
// - Set number is the binary value of the inputs, bit2 most significant.
`ifndef WTS_DEFINES_SVH
`define WTS_DEFINES_SVH
`define WTS_ADDR_CTRL 12'h000
`define WTS_ADDR_FRIC 12'h004
`define WTS_ADDR_GEAR 12'h008
`define WTS_ADDR_FILT 12'h00c
`define WTS_ADDR_STAT 12'h010
`define WTS_ADDR_TORQ 12'h014
`define WTS_ADDR_APPLY 12'h018
`define WTS_SET_BASE 12'h100
`define WTS_FIELD_CMD 3'h0
`define WTS_FIELD_THICK 3'h1
`define WTS_FIELD_INIT 3'h2
`define WTS_FIELD_FINAL 3'h3
`define WTS_FIELD_TAPER 3'h4
`define WTS_FIELD_CORE 3'h5
`define WTS_FIELD_MATL 3'h6
`define WTS_THICK_MAX 32'h0000_1388
`define WTS_THICK_DEF 16'h0032
`define WTS_DIA_MAX 32'h0000_03e8
`define WTS_INIT_DEF 16'h01f4
`define WTS_FINAL_DEF 16'h03e8
`define WTS_INERTIA_MAX 32'h0098_967f
`define WTS_PCT_MAX 32'h0000_0064
`define WTS_TAPER_DEF 7'h64
`define WTS_FRIC_MAX 32'h0000_0032
`define WTS_GEAR_MIN 32'h0000_000a
`define WTS_GEAR_MAX 32'h0000_2710
`define WTS_GEAR_DEF 14'h000a
`define WTS_FILT_MIN 32'h0000_000a
`define WTS_FILT_MAX 32'h0000_01f4
`define WTS_FILT_DEF 9'h064
`define WTS_RESP_OKAY 2'h0
`define WTS_RESP_SLVERR 2'h2
`endif

// >>> src/wts_pkg.sv
// Types shared by the tension setpoint block.
package wts_pkg;
  typedef enum logic [1:0] {
    WTS_MODE_SIMPLE = 2'b00,
    WTS_MODE_HIGH1 = 2'b01,
    WTS_MODE_HIGH2 = 2'b10
  } wts_mode_t;
  typedef enum logic {
    WTS_IDLE = 1'b0,
    WTS_RUN = 1'b1
  } wts_state_t;
  typedef struct packed {
    logic hit;
    logic isSet;
    logic [2:0] set;
    logic [2:0] field;
  } wts_dec_t;
  typedef struct packed {
    logic excite;
    logic dirForward;
    logic winding;
    logic unwinding;
    logic [7:0] torque;
    logic [8:0] filterMs;
  } wts_drive_t;
endpackage : wts_pkg

// >>> src/wts_tension_ctrl.sv
// Tension setpoint logic with eight data sets and an AXI4-Lite register slave.
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "wts_defines.svh"
module wts_tension_ctrl (
  input wire logic clk, // 50 MHz clock
  input wire logic reset, // synchronous, active high
  input wire logic [11:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [11:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic data_select_bit0, // set select, lsb
  input wire logic data_select_bit1, // set select
  input wire logic data_select_bit2, // set select, msb
  input wire logic forward_run_input, // run request
  input wire logic reverse_run_input, // unused in high function modes
  input wire logic [9:0] rollDiameter, // present roll diameter in mm
  output wts_pkg::wts_drive_t drive // motor command bundle
);
  logic [6:0] cmdSet_q [8];
  logic [15:0] thick_q [8];
  logic [15:0] initDia_q [8];
  logic [15:0] finalDia_q [8];
  logic [6:0] taper_q [8];
  logic [23:0] coreInertia_q [8];
  logic [23:0] matlInertia_q [8];
  logic [1:0] mode_q;
  logic dirPend_q, dirAct_q;
  logic [13:0] gearPend_q, gearAct_q;
  logic [5:0] fric_q;
  logic [8:0] filt_q;
  wts_pkg::wts_state_t state_q;
  logic [2:0] activeSet_q;
  logic [7:0] torque_q;
  logic [2:0] divCnt_q;
  logic [31:0] rem_q;
  logic [6:0] quot_q;
  logic wrFire, rdFire;
  wts_pkg::wts_dec_t wDec, rDec;
  logic [2:0] selNow;
  logic winding, unwinding, running;
  logic [15:0] maxDia, diaUse;
  logic [31:0] num, den;
  logic [39:0] denShift;
  logic [7:0] torqueSum;

  function automatic wts_pkg::wts_dec_t decode(input logic [11:0] a);
    wts_pkg::wts_dec_t d;
    d = '0;
    if (a >= `WTS_SET_BASE) begin
      d.isSet = 1'b1;
      d.set = a[7:5];
      d.field = a[4:2];
      d.hit = (a[11:8] == 4'h1) && (a[4:2] <= `WTS_FIELD_MATL) && (a[1:0] == 2'h0);
    end else begin
      d.hit = (a <= `WTS_ADDR_APPLY) && (a[1:0] == 2'h0);
    end
    return d;
  endfunction : decode

  function automatic logic inRange(input logic [31:0] v, input logic [31:0] lo,
                                   input logic [31:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction : inRange

  assign selNow = {data_select_bit2, data_select_bit1, data_select_bit0};
  assign running = (state_q == wts_pkg::WTS_RUN);
  assign wDec = decode(awaddr);
  assign rDec = decode(araddr);
  // Both channels are taken together, so the slave never has to park a lone address.
  assign wrFire = awvalid && wvalid && !bvalid;
  assign awready = wrFire;
  assign wready = wrFire;
  assign rdFire = arvalid && !rvalid;
  assign arready = rdFire;

  always_ff @(posedge clk) begin
    if (reset) begin
      bvalid <= 1'b0;
      bresp <= `WTS_RESP_OKAY;
    end else if (wrFire) begin
      bvalid <= 1'b1;
      bresp <= wDec.hit ? `WTS_RESP_OKAY : `WTS_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Out-of-range writes are dropped so a set always holds a legal value.
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < 8; i++) begin
        cmdSet_q[i] <= 7'h00;
        thick_q[i] <= `WTS_THICK_DEF;
        initDia_q[i] <= `WTS_INIT_DEF;
        finalDia_q[i] <= `WTS_FINAL_DEF;
        taper_q[i] <= `WTS_TAPER_DEF;
        coreInertia_q[i] <= 24'h000000;
        matlInertia_q[i] <= 24'h000000;
      end
    end else if (wrFire && wDec.hit && wDec.isSet && (&wstrb)) begin
      case (wDec.field)
        `WTS_FIELD_CMD: if (wdata <= `WTS_PCT_MAX) cmdSet_q[wDec.set] <= wdata[6:0];
        `WTS_FIELD_THICK: if (inRange(wdata, 32'h1, `WTS_THICK_MAX)) begin
          thick_q[wDec.set] <= wdata[15:0];
        end
        `WTS_FIELD_INIT: if (inRange(wdata, 32'h1, `WTS_DIA_MAX)) begin
          initDia_q[wDec.set] <= wdata[15:0];
        end
        `WTS_FIELD_FINAL: if (inRange(wdata, 32'h1, `WTS_DIA_MAX)) begin
          finalDia_q[wDec.set] <= wdata[15:0];
        end
        `WTS_FIELD_TAPER: if (wdata <= `WTS_PCT_MAX) taper_q[wDec.set] <= wdata[6:0];
        `WTS_FIELD_CORE: if (wdata <= `WTS_INERTIA_MAX) begin
          coreInertia_q[wDec.set] <= wdata[23:0];
        end
        `WTS_FIELD_MATL: if (wdata <= `WTS_INERTIA_MAX) begin
          matlInertia_q[wDec.set] <= wdata[23:0];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mode_q <= wts_pkg::WTS_MODE_HIGH1;
      dirPend_q <= 1'b1;
      gearPend_q <= `WTS_GEAR_DEF;
      fric_q <= 6'h00;
      filt_q <= `WTS_FILT_DEF;
    end else if (wrFire && wDec.hit && !wDec.isSet && (&wstrb)) begin
      case (awaddr)
        `WTS_ADDR_CTRL: begin
          if (wdata[1:0] != 2'h3) mode_q <= wdata[1:0];
          dirPend_q <= wdata[8];
        end
        `WTS_ADDR_FRIC: if (wdata <= `WTS_FRIC_MAX) fric_q <= wdata[5:0];
        `WTS_ADDR_GEAR: if (inRange(wdata, `WTS_GEAR_MIN, `WTS_GEAR_MAX)) begin
          gearPend_q <= wdata[13:0];
        end
        `WTS_ADDR_FILT: if (inRange(wdata, `WTS_FILT_MIN, `WTS_FILT_MAX)) begin
          filt_q <= wdata[8:0];
        end
        default: ;
      endcase
    end
  end

  // System values only move at reset or at a reload request while stopped.
  always_ff @(posedge clk) begin
    if (reset) begin
      dirAct_q <= 1'b1;
      gearAct_q <= `WTS_GEAR_DEF;
    end else if (wrFire && (awaddr == `WTS_ADDR_APPLY) && wdata[0] && !running) begin
      dirAct_q <= dirPend_q;
      gearAct_q <= gearPend_q;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rvalid <= 1'b0;
      rresp <= `WTS_RESP_OKAY;
      rdata <= 32'h0000_0000;
    end else if (rdFire) begin
      rvalid <= 1'b1;
      rresp <= rDec.hit ? `WTS_RESP_OKAY : `WTS_RESP_SLVERR;
      rdata <= 32'h0000_0000;
      if (rDec.hit && rDec.isSet) begin
        case (rDec.field)
          `WTS_FIELD_CMD: rdata <= {25'h0, cmdSet_q[rDec.set]};
          `WTS_FIELD_THICK: rdata <= {16'h0, thick_q[rDec.set]};
          `WTS_FIELD_INIT: rdata <= {16'h0, initDia_q[rDec.set]};
          `WTS_FIELD_FINAL: rdata <= {16'h0, finalDia_q[rDec.set]};
          `WTS_FIELD_TAPER: rdata <= {25'h0, taper_q[rDec.set]};
          `WTS_FIELD_CORE: rdata <= {8'h0, coreInertia_q[rDec.set]};
          default: rdata <= {8'h0, matlInertia_q[rDec.set]};
        endcase
      end else if (rDec.hit) begin
        case (araddr)
          `WTS_ADDR_CTRL: rdata <= {23'h0, dirPend_q, 6'h0, mode_q};
          `WTS_ADDR_FRIC: rdata <= {26'h0, fric_q};
          `WTS_ADDR_GEAR: rdata <= {18'h0, gearPend_q};
          `WTS_ADDR_FILT: rdata <= {23'h0, filt_q};
          `WTS_ADDR_STAT: rdata <= {2'h0, gearAct_q, 7'h0, dirAct_q, 1'b0, activeSet_q,
                                    1'b0, unwinding, winding, running};
          `WTS_ADDR_TORQ: rdata <= {24'h0, torque_q};
          default: rdata <= 32'h0000_0000;
        endcase
      end
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // Reverse run input plays no part in starting or stopping.
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= wts_pkg::WTS_IDLE;
      activeSet_q <= 3'h0;
    end else begin
      case (state_q)
        wts_pkg::WTS_IDLE: begin
          activeSet_q <= selNow;
          if (forward_run_input) state_q <= wts_pkg::WTS_RUN;
        end
        wts_pkg::WTS_RUN: begin
          if (!forward_run_input) state_q <= wts_pkg::WTS_IDLE;
        end
        default: state_q <= wts_pkg::WTS_IDLE;
      endcase
    end
  end

  assign winding = initDia_q[activeSet_q] < finalDia_q[activeSet_q];
  assign unwinding = initDia_q[activeSet_q] > finalDia_q[activeSet_q];
  assign maxDia = unwinding ? initDia_q[activeSet_q] : finalDia_q[activeSet_q];
  assign diaUse = ({6'h0, rollDiameter} > maxDia) ? maxDia : {6'h0, rollDiameter};
  // Quotient = cmd*(100*max - (100-taper)*dia)*10 / (100*max*gear10); never above cmd.
  assign num = 32'(cmdSet_q[activeSet_q]) * (32'h0000_0064 * 32'(maxDia)
             - 32'(7'h64 - taper_q[activeSet_q]) * 32'(diaUse)) * 32'h0000_000a;
  assign den = 32'h0000_0064 * 32'(maxDia) * 32'(gearAct_q);
  assign denShift = {8'h0, den} << divCnt_q;
  assign torqueSum = {1'b0, quot_q} + {2'h0, fric_q};

  // One quotient bit per cycle; a fresh result lands every eighth cycle.
  always_ff @(posedge clk) begin
    if (reset || !running) begin
      divCnt_q <= 3'h7;
      rem_q <= 32'h0000_0000;
      quot_q <= 7'h00;
      torque_q <= 8'h00;
    end else if (divCnt_q == 3'h7) begin
      divCnt_q <= 3'h6;
      rem_q <= num;
      quot_q <= 7'h00;
    end else begin
      if ({8'h0, rem_q} >= denShift) begin
        rem_q <= rem_q - denShift[31:0];
        quot_q[divCnt_q] <= 1'b1;
      end
      divCnt_q <= divCnt_q - 3'h1;
    end
    if (!reset && running && divCnt_q == 3'h0) begin
      // The last quotient bit is added, not ORed, so an odd friction value cannot swallow it.
      torque_q <= ({8'h0, rem_q} >= denShift) ? torqueSum + 8'h01 : torqueSum;
    end
  end

  assign drive.excite = running;
  assign drive.dirForward = dirAct_q;
  assign drive.winding = winding;
  assign drive.unwinding = unwinding;
  assign drive.torque = torque_q;
  assign drive.filterMs = filt_q;

  AST_SET_HOLD: assert property (@(posedge clk) disable iff (reset)
    running && $past(running) |-> $stable(activeSet_q))
    else $error("active set moved during run");
  AST_SET_PICK: assert property (@(posedge clk) disable iff (reset)
    !running |=> activeSet_q == $past(selNow))
    else $error("idle set does not follow inputs");
  AST_START: assert property (@(posedge clk) disable iff (reset)
    !running && forward_run_input |=> drive.excite)
    else $error("run did not start");
  AST_COAST: assert property (@(posedge clk) disable iff (reset)
    !forward_run_input |=> !drive.excite)
    else $error("excitation kept after release");
  AST_WIND: assert property (@(posedge clk) disable iff (reset)
    running && winding |-> maxDia == finalDia_q[activeSet_q] && !unwinding)
    else $error("winding maximum wrong");
  AST_UNWIND: assert property (@(posedge clk) disable iff (reset)
    unwinding |-> maxDia == initDia_q[activeSet_q])
    else $error("unwinding maximum wrong");
  // With a flat taper and unit gear the result must be the command itself plus friction.
  AST_FLAT: assert property (@(posedge clk) disable iff (reset)
    running && divCnt_q == 3'h0 && taper_q[activeSet_q] == 7'h64 && gearAct_q == 14'h000a
    |=> !running || torque_q == {1'b0, $past(cmdSet_q[activeSet_q])} + {2'h0, $past(fric_q)})
    else $error("flat taper changed tension");
  AST_GEAR_HOLD: assert property (@(posedge clk) disable iff (reset)
    running |=> $stable(gearAct_q) && $stable(dirAct_q))
    else $error("system value changed while running");
  AST_THICK: assert property (@(posedge clk) disable iff (reset)
    thick_q[activeSet_q] != 16'h0 && thick_q[activeSet_q] <= 16'h1388)
    else $error("thickness out of range");
  AST_BRESP: assert property (@(posedge clk) disable iff (reset)
    wrFire |=> bvalid)
    else $error("write not answered");
  COV_RUN: cover property (@(posedge clk) disable iff (reset) running ##8 !running);
  COV_UNWIND: cover property (@(posedge clk) disable iff (reset) running && unwinding);
  COV_TAPER: cover property (@(posedge clk) disable iff (reset)
    running && taper_q[activeSet_q] < 7'h64 && torque_q != 8'h00);
endmodule : wts_tension_ctrl

// >>> bench/wts_host_model.sv
// Host controller model that drives the data selection and run lines.
`timescale 1ns/100ps
module wts_host_model (
  input wire logic clk, // bench clock
  input wire logic reset, // synchronous reset
  input wire logic [2:0] reqSet, // set number wanted by the bench
  input wire logic reqRun, // forward run wanted
  input wire logic reqRev, // reverse run wanted
  output logic selBit0, // selection lsb
  output logic selBit1, // selection middle bit
  output logic selBit2, // selection msb
  output logic fwdRun, // forward run line
  output logic revRun // reverse run line
);
  // Lines move one scan after the request, as a controller output stage would.
  always_ff @(posedge clk) begin
    if (reset) begin
      {selBit2, selBit1, selBit0} <= 3'h0;
      fwdRun <= 1'b0;
      revRun <= 1'b0;
    end else begin
      {selBit2, selBit1, selBit0} <= reqSet;
      fwdRun <= reqRun;
      revRun <= reqRev;
    end
  end
endmodule : wts_host_model

// >>> bench/testbench.sv
// Self-checking bench for the tension setpoint block.
`timescale 1ns/100ps
`include "wts_defines.svh"
module testbench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp;
  logic [9:0] rollDiameter = 10'h000;
  logic [2:0] reqSet = 3'h0;
  logic reqRun = 1'b0, reqRev = 1'b0;
  logic sel0, sel1, sel2, fwdRun, revRun;
  wts_pkg::wts_drive_t drive;
  logic [31:0] seed = 32'h0000_e86a;
  int nFail = 0, nCompared = 0, gear10 = 10, fric = 0;
  int ini[8] = '{default: 500};
  int fin[8] = '{default: 1000};
  int defv[7] = '{0, 50, 500, 1000, 100, 0, 0};

  always #10 clk = ~clk;

  wts_tension_ctrl dut (.clk, .reset, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .data_select_bit0(sel0), .data_select_bit1(sel1), .data_select_bit2(sel2),
    .forward_run_input(fwdRun), .reverse_run_input(revRun), .rollDiameter, .drive);
  wts_host_model host (.clk, .reset, .reqSet, .reqRun, .reqRev, .selBit0(sel0),
    .selBit1(sel1), .selBit2(sel2), .fwdRun, .revRun);

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [11:0] setAddr(int s, int f);
    return 12'h100 + 12'(32 * s + 4 * f);
  endfunction : setAddr

  // Maximum diameter is the larger end of the roll; the diameter is clamped to it.
  function automatic logic [31:0] expTorque(int c, int tp, int a, int b, int d);
    longint mx;
    mx = (a > b) ? a : b;
    if (d > mx) d = int'(mx);
    return 32'((c * (100 * mx - (100 - tp) * d) * 10) / (100 * mx * gear10) + fric);
  endfunction : expTorque

  task automatic checkWord(input string what, input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      nFail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : checkWord

  // Waits have no limit of their own; a hung slave is caught by the watchdog.
  task automatic axiWrite(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge clk); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    do @(posedge clk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : axiWrite

  task automatic axiRead(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axiRead

  task automatic readChk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] re);
    axiRead(a, rd, rsp);
    checkWord("read data", rd, e);
    checkWord("read response", 32'(rsp), 32'(re));
  endtask : readChk

  task automatic wrChk(input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
    axiWrite(a, d, rsp);
    checkWord("write response", 32'(rsp), 32'(`WTS_RESP_OKAY));
    readChk(a, e, `WTS_RESP_OKAY);
  endtask : wrChk

  task automatic doRun(input int s, c, tp, a, b, dia, input logic dir);
    axiWrite(setAddr(s, 0), 32'(c), rsp);
    axiWrite(setAddr(s, 2), 32'(a), rsp);
    axiWrite(setAddr(s, 3), 32'(b), rsp);
    axiWrite(setAddr(s, 4), 32'(tp), rsp);
    reqSet <= 3'(s);
    rollDiameter <= 10'(dia);
    repeat (3) @(posedge clk);
    reqRun <= 1'b1;
    repeat (20) @(posedge clk);
    reqSet <= 3'(s ^ 5);
    checkWord("excite", 32'(drive.excite), 32'h1);
    checkWord("torque", 32'(drive.torque), expTorque(c, tp, a, b, dia));
    checkWord("direction", 32'(drive.dirForward), 32'(dir));
    checkWord("wind", 32'({drive.winding, drive.unwinding}), 32'({a < b, a > b}));
    rollDiameter <= 10'(rnd());
    repeat (20) @(posedge clk);
    checkWord("torque", 32'(drive.torque), expTorque(c, tp, a, b, rollDiameter));
    axiRead(`WTS_ADDR_STAT, rd, rsp);
    checkWord("active set", 32'(rd[6:4]), 32'(s));
    reqRun <= 1'b0;
    // Host stage, state register and torque register each add one edge.
    repeat (4) @(posedge clk);
    checkWord("stop", 32'({drive.excite, drive.torque}), 32'h0);
  endtask : doRun

  task automatic conclude();
    $display("Compared %0d, mismatches %0d", nCompared, nFail);
    if (nFail == 0 && nCompared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  // The whole sequence needs about eight hundred cycles, so this only cuts a hang.
  initial begin
    repeat (20000) @(posedge clk);
    nFail++;
    conclude();
  end

  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (int s = 0; s < 8; s++) begin
      for (int f = 0; f < 7; f++) begin
        readChk(setAddr(s, f), 32'(defv[f]), `WTS_RESP_OKAY);
      end
    end
    readChk(`WTS_ADDR_CTRL, 32'h0000_0101, `WTS_RESP_OKAY);
    readChk(`WTS_ADDR_FRIC, 32'h0, `WTS_RESP_OKAY);
    readChk(`WTS_ADDR_GEAR, 32'h0000_000a, `WTS_RESP_OKAY);
    readChk(`WTS_ADDR_FILT, 32'h0000_0064, `WTS_RESP_OKAY);
    checkWord("filter", 32'(drive.filterMs), 32'h0000_0064);
    readChk(12'h01c, 32'h0, `WTS_RESP_SLVERR);
    $display("Test defaults done");
    wrChk(setAddr(7, 1), 32'h0000_1389, 32'h0000_0032);
    wrChk(setAddr(7, 1), 32'h0000_1388, 32'h0000_1388);
    wrChk(setAddr(7, 2), 32'h0, 32'h0000_01f4);
    wrChk(setAddr(7, 2), 32'h0000_03e8, 32'h0000_03e8);
    wrChk(setAddr(7, 3), 32'h0000_03e9, 32'h0000_03e8);
    wrChk(setAddr(7, 4), 32'h0000_0065, 32'h0000_0064);
    wrChk(setAddr(7, 5), 32'h0098_967f, 32'h0098_967f);
    wrChk(setAddr(7, 6), 32'h0098_9680, 32'h0);
    wrChk(`WTS_ADDR_FRIC, 32'h0000_0033, 32'h0);
    wrChk(`WTS_ADDR_FRIC, 32'h0000_0032, 32'h0000_0032);
    wstrb <= 4'h3;
    wrChk(`WTS_ADDR_FRIC, 32'h0000_0010, 32'h0000_0032);
    wstrb <= 4'hf;
    wrChk(`WTS_ADDR_GEAR, 32'h0000_0009, 32'h0000_000a);
    wrChk(`WTS_ADDR_GEAR, 32'h0000_2711, 32'h0000_000a);
    wrChk(`WTS_ADDR_FILT, 32'h0000_0009, 32'h0000_0064);
    wrChk(`WTS_ADDR_FILT, 32'h0000_01f4, 32'h0000_01f4);
    checkWord("filter", 32'(drive.filterMs), 32'h0000_01f4);
    wrChk(setAddr(3, 2), 32'h0000_0320, 32'h0000_0320);
    wrChk(setAddr(3, 3), 32'h0000_00c8, 32'h0000_00c8);
    axiWrite(12'h01c, 32'h0000_0055, rsp);
    checkWord("unmapped write", 32'(rsp), 32'(`WTS_RESP_SLVERR));
    fric = 50;
    ini[7] = 1000;
    ini[3] = 800;
    fin[3] = 200;
    $display("Test ranges done");
    reqRev <= 1'b1;
    for (int s = 0; s < 8; s++) begin
      reqSet <= 3'(s);
      repeat (3) @(posedge clk);
      axiRead(`WTS_ADDR_STAT, rd, rsp);
      checkWord("status", rd & 32'h0000_0077,
        32'((s << 4) | ((ini[s] > fin[s]) << 2) | ((ini[s] < fin[s]) << 1)));
    end
    $display("Test selection done");
    doRun(0, 80, 100, 200, 900, 500, 1'b1);
    doRun(2, 80, 50, 300, 1000, 1023, 1'b1);
    repeat (6) begin
      doRun(int'(rnd() % 8), int'(rnd() % 101), int'(rnd() % 101), int'(rnd() % 1000 + 1),
        int'(rnd() % 1000 + 1), int'(rnd() % 1024), 1'b1);
    end
    $display("Test torque done");
    axiWrite(`WTS_ADDR_GEAR, 32'h0000_0014, rsp);
    axiWrite(`WTS_ADDR_CTRL, 32'h0000_0002, rsp);
    doRun(4, 90, 70, 600, 100, 300, 1'b1);
    axiWrite(`WTS_ADDR_APPLY, 32'h0000_0001, rsp);
    gear10 = 20;
    doRun(4, 90, 70, 600, 100, 300, 1'b0);
    $display("Test apply done");
    conclude();
  end
endmodule : testbench
